// [rtl/smp_device.sv]
// Serial port end: master or slave shift engine with an APB register slave.
//
// Chosen here: the APB register port and the register offsets.
module smp_device (
  input wire logic i_sys_clk, // System clock, 10 MHz.
  input wire logic i_rst_b, // Asynchronous reset, active low.
  input wire logic i_psel, // APB select.
  input wire logic i_penable, // APB enable.
  input wire logic i_pwrite, // APB direction, high for write.
  input wire logic [11:0] i_paddr, // APB byte address.
  input wire logic [31:0] i_pwdata, // APB write data.
  output logic o_pready, // APB ready.
  output logic o_pslverr, // APB error for unmapped address.
  output logic [31:0] o_prdata, // APB read data.
  output logic o_irq_req, // Receive or mode-fault interrupt request.
  smp_link_if.dev link // Serial bus.
);
  import smp_pkg::*;
  logic [7:0] ctrl_q;
  smp_state_t state_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic [3:0] cnt_q;
  logic [6:0] div_q;
  logic sck_q;
  logic bit_q;
  logic sck_prev_q;
  logic ss_prev_q;
  logic drv_q;
  logic miso_oe_q;
  logic done_q;
  logic write_collision_flag_q;
  logic sserr_q;
  logic mode_fault_flag_q;
  logic arm_flags_q;
  logic arm_mode_fault_flag_q;
  logic en;
  logic master_select_bit;
  logic clock_phase_select;
  logic cpol;
  logic select_pin_disable;
  logic [2:0] rate;
  logic rate_ok;
  logic setup;
  logic access;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_data;
  logic wr_ctrl;
  logic wr_data;
  logic rd_stat;
  logic acc_data;
  logic selected;
  logic slave_act;
  logic busy;
  logic mode_fault_flag_set;
  logic ev;
  logic lead;
  logic samp;
  logic shft;
  logic last;
  logic in_bit;
  logic fin;
  logic start;

  // Control fields.
  assign en = ctrl_q[SMP_CTL_EN];
  assign master_select_bit = ctrl_q[SMP_CTL_MASTER_SELECT_BIT];
  assign clock_phase_select = ctrl_q[SMP_CTL_CLOCK_PHASE_SELECT];
  assign cpol = ctrl_q[SMP_CTL_CPOL];
  assign select_pin_disable = ctrl_q[SMP_CTL_SELECT_PIN_DISABLE];
  assign rate = ctrl_q[SMP_CTL_RATE_LSB +: 3];
  assign rate_ok = (rate >= SMP_RATE_MIN) && (rate <= SMP_RATE_MAX);

  // Register bus decode; a request takes effect in its single access cycle.
  assign setup = i_psel & ~i_penable;
  assign access = i_psel & i_penable & o_pready;
  assign hit_ctrl = (i_paddr == SMP_CTRL_OFF);
  assign hit_stat = (i_paddr == SMP_STAT_OFF);
  assign hit_data = (i_paddr == SMP_DATA_OFF);
  assign wr_ctrl = access & i_pwrite & hit_ctrl;
  assign wr_data = access & i_pwrite & hit_data;
  assign rd_stat = access & ~i_pwrite & hit_stat;
  assign acc_data = access & hit_data;

  // Selection; phase 1 with select disabled keeps a slave permanently selected.
  assign selected = ~link.ss_n | (clock_phase_select & select_pin_disable);
  assign slave_act = en & ~master_select_bit & selected;
  assign busy = (state_q == SMP_XFER) | (~master_select_bit & (cnt_q != 4'h0));
  assign mode_fault_flag_set = en & master_select_bit & ~select_pin_disable & ~link.ss_n;
  assign start = wr_data & ~busy & en & master_select_bit & rate_ok & (state_q == SMP_IDLE);

  // Edge events: timer ticks as master, observed clock changes as slave.
  assign lead = master_select_bit ? ~cnt_q[0] : (link.sck == ~cpol);
  assign ev = master_select_bit ? (state_q == SMP_XFER && div_q == 7'h00)
                   : (slave_act && link.sck != sck_prev_q);
  assign samp = ev & (lead == ~clock_phase_select);
  assign shft = ev & ~samp;
  assign last = (cnt_q == SMP_LAST_EDGE);
  assign in_bit = master_select_bit ? link.miso : link.mosi;
  assign fin = (samp & clock_phase_select & last) | (shft & ~clock_phase_select & last);

  // Pins come straight from flops; the shift register's top bit feeds both data lines.
  assign link.dev_sck = sck_q;
  assign link.dev_sck_oe = drv_q;
  assign link.dev_mosi = sh_q[7];
  assign link.dev_mosi_oe = drv_q;
  assign link.dev_miso = sh_q[7];
  assign link.dev_miso_oe = miso_oe_q;

  // APB answer: ready in the cycle after setup, read data latched at setup.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end
    else
    begin
      o_pready <= setup;
      o_pslverr <= setup & ~(hit_ctrl | hit_stat | hit_data);
      if (setup && !i_pwrite)
      begin
        if (hit_ctrl)
          o_prdata <= {24'h00_0000, ctrl_q};
        else if (hit_stat)
          o_prdata <= {24'h00_0000, done_q, write_collision_flag_q, sserr_q, mode_fault_flag_q, 3'h0, busy};
        else if (hit_data)
          o_prdata <= {24'h00_0000, rx_q};
        else
          o_prdata <= 32'h0000_0000;
      end
    end
  end

  // Control register; a mode fault drops enable and master select.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      ctrl_q <= SMP_CTRL_RESET;
    else if (mode_fault_flag_set)
    begin
      ctrl_q[SMP_CTL_EN] <= 1'b0;
      ctrl_q[SMP_CTL_MASTER_SELECT_BIT] <= 1'b0;
    end
    else if (wr_ctrl)
      ctrl_q <= i_pwdata[7:0];
  end

  // Status flags; a setting event always wins over a clear in the same cycle.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      sserr_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      arm_flags_q <= 1'b0;
      arm_mode_fault_flag_q <= 1'b0;
      o_irq_req <= 1'b0;
    end
    else
    begin
      if (rd_stat && (done_q || write_collision_flag_q))
        arm_flags_q <= 1'b1;
      else if (acc_data)
        arm_flags_q <= 1'b0;
      if (rd_stat && mode_fault_flag_q)
        arm_mode_fault_flag_q <= 1'b1;
      else if (wr_ctrl)
        arm_mode_fault_flag_q <= 1'b0;
      done_q <= fin | (done_q & ~(acc_data & arm_flags_q));
      write_collision_flag_q <= (wr_data & busy) | (write_collision_flag_q & ~(acc_data & arm_flags_q));
      mode_fault_flag_q <= mode_fault_flag_set | (mode_fault_flag_q & ~(wr_ctrl & arm_mode_fault_flag_q));
      sserr_q <= (en & ~master_select_bit & ~(clock_phase_select & select_pin_disable) & link.ss_n & ~ss_prev_q & (cnt_q != 4'h0))
               | (sserr_q & ~(wr_ctrl & ~i_pwdata[SMP_CTL_EN]));
      o_irq_req <= done_q | mode_fault_flag_q;
    end
  end

  // Bus drive enables: master lines while master, data out only while selected as slave.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      drv_q <= 1'b0;
      miso_oe_q <= 1'b0;
      sck_prev_q <= 1'b1;
      ss_prev_q <= 1'b1;
    end
    else
    begin
      drv_q <= en & master_select_bit & ~mode_fault_flag_set;
      miso_oe_q <= en & ~master_select_bit & selected;
      sck_prev_q <= link.sck;
      ss_prev_q <= link.ss_n;
    end
  end

  // Master sequencer and clock divider; half period is 2 to 64 system clocks.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q <= SMP_IDLE;
      div_q <= 7'h00;
      sck_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        SMP_IDLE:
        begin
          sck_q <= cpol;
          div_q <= 7'((7'h01 << rate) - 7'h01);
          if (start)
            state_q <= SMP_XFER;
        end
        SMP_XFER:
        begin
          if (div_q != 7'h00)
            div_q <= div_q - 7'h01;
          else
          begin
            div_q <= 7'((7'h01 << rate) - 7'h01);
            sck_q <= ~sck_q;
          end
          if (fin || !en || !master_select_bit)
            state_q <= SMP_IDLE;
        end
      endcase
    end
  end

  // Shift engine: in is sampled and out shifts on opposite edges, sixteen edges per byte.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      cnt_q <= 4'h0;
      bit_q <= 1'b0;
    end
    else
    begin
      if (wr_data && !busy)
        sh_q <= i_pwdata[7:0];
      if (!en || (!master_select_bit && !selected) || start)
        cnt_q <= 4'h0;
      else if (ev)
        cnt_q <= cnt_q + 4'h1;
      if (samp)
        bit_q <= in_bit;
      if (shft && !(clock_phase_select && cnt_q == 4'h0) && !(wr_data && !busy))
        sh_q <= {sh_q[6:0], bit_q};
      if (samp && clock_phase_select && last)
        rx_q <= {sh_q[6:0], in_bit};
      if (shft && !clock_phase_select && last)
        rx_q <= {sh_q[6:0], bit_q};
    end
  end
endmodule : smp_device

// [rtl/smp_pkg.sv]
// Package with the register map, field positions and state codes of the serial port.
package smp_pkg;
  // Register byte offsets on the register bus.
  localparam logic [11:0] SMP_CTRL_OFF = 12'h000;
  localparam logic [11:0] SMP_STAT_OFF = 12'h004;
  localparam logic [11:0] SMP_DATA_OFF = 12'h008;
  // Control register fields.
  localparam int SMP_CTL_RATE_LSB = 0;
  localparam int SMP_CTL_CLOCK_PHASE_SELECT = 3;
  localparam int SMP_CTL_CPOL = 4;
  localparam int SMP_CTL_SELECT_PIN_DISABLE = 5;
  localparam int SMP_CTL_MASTER_SELECT_BIT = 6;
  localparam int SMP_CTL_EN = 7;
  localparam logic [7:0] SMP_CTRL_RESET = 8'h00;
  // Status register fields.
  localparam int SMP_ST_BUSY = 0;
  localparam int SMP_ST_MODE_FAULT_FLAG = 4;
  localparam int SMP_ST_SSERR = 5;
  localparam int SMP_ST_WRITE_COLLISION_FLAG = 6;
  localparam int SMP_ST_DONE = 7;
  // Valid rate codes and the last edge index of a byte.
  localparam logic [2:0] SMP_RATE_MIN = 3'h1;
  localparam logic [2:0] SMP_RATE_MAX = 3'h6;
  localparam logic [3:0] SMP_LAST_EDGE = 4'hf;
  // Transfer engine states.
  typedef enum logic [1:0] {
    SMP_IDLE = 2'b01,
    SMP_XFER = 2'b10
  } smp_state_t;
endpackage : smp_pkg

// [rtl/smp_link_if.sv]
// Interface carrying the four serial bus lines between the port and its partner.
interface smp_link_if;
  logic dev_sck;
  logic dev_sck_oe;
  logic dev_mosi;
  logic dev_mosi_oe;
  logic dev_miso;
  logic dev_miso_oe;
  logic peer_sck;
  logic peer_sck_oe;
  logic peer_mosi;
  logic peer_mosi_oe;
  logic peer_miso;
  logic peer_miso_oe;
  logic peer_ss_n;
  logic peer_ss_n_oe;
  logic sck;
  logic mosi;
  logic miso;
  logic ss_n;
  // Resolved line levels; an undriven line is pulled high.
  assign sck = dev_sck_oe ? dev_sck : (peer_sck_oe ? peer_sck : 1'b1);
  assign mosi = dev_mosi_oe ? dev_mosi : (peer_mosi_oe ? peer_mosi : 1'b1);
  assign miso = dev_miso_oe ? dev_miso : (peer_miso_oe ? peer_miso : 1'b1);
  assign ss_n = peer_ss_n_oe ? peer_ss_n : 1'b1;
  modport dev (
    output dev_sck, dev_sck_oe, dev_mosi, dev_mosi_oe, dev_miso, dev_miso_oe,
    input sck, mosi, miso, ss_n
  );
  modport peer (
    output peer_sck, peer_sck_oe, peer_mosi, peer_mosi_oe, peer_miso, peer_miso_oe,
    output peer_ss_n, peer_ss_n_oe,
    input sck, mosi, miso, ss_n
  );
endinterface : smp_link_if

// [rtl/smp_peer.sv]
// Partner end of the serial bus: a simple external master or slave with a plain user port.
module smp_peer #(
  parameter int unsigned HALF = 2
) (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_rst_b, // Asynchronous reset, active low.
  input wire logic i_master, // High to act as bus master.
  input wire logic i_sel, // Slave mode: this partner is selected.
  input wire logic i_cpol, // Idle clock level.
  input wire logic i_clock_phase_select, // Clock phase.
  input wire logic i_start, // Master mode: start one byte.
  input wire logic [7:0] i_tx, // Byte to send.
  output logic [7:0] o_rx, // Last byte received.
  output logic o_done, // One-cycle pulse at the end of a byte.
  output logic o_busy, // Master transfer in progress.
  smp_link_if.peer link // Serial bus.
);
  import smp_pkg::*;
  smp_state_t state_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic [15:0] div_q;
  logic sck_q;
  logic bit_q;
  logic prev_q;
  logic ev;
  logic lead;
  logic samp;
  logic shft;
  logic last;
  logic in_bit;
  logic fin;

  // Edge events come from the half-period timer as master, from the line as slave.
  assign lead = i_master ? ~cnt_q[0] : (link.sck == ~i_cpol);
  assign ev = i_master ? (state_q == SMP_XFER && div_q == 16'h0000)
                       : (i_sel && link.sck != prev_q);
  assign samp = ev & (lead == ~i_clock_phase_select);
  assign shft = ev & ~samp;
  assign last = (cnt_q == SMP_LAST_EDGE);
  assign in_bit = i_master ? link.miso : link.mosi;
  assign fin = (samp & i_clock_phase_select & last) | (shft & ~i_clock_phase_select & last);

  // Bus drive: a master owns clock, data out and select; a slave only its data out.
  assign link.peer_sck = sck_q;
  assign link.peer_sck_oe = i_master;
  assign link.peer_mosi = sh_q[7];
  assign link.peer_mosi_oe = i_master;
  // Select stays low one cycle past the last clock edge, so a slave that sees edges a cycle late still counts it.
  assign link.peer_ss_n = ~((state_q == SMP_XFER) | o_busy);
  assign link.peer_ss_n_oe = i_master;
  assign link.peer_miso = sh_q[7];
  assign link.peer_miso_oe = ~i_master & i_sel;

  // Master sequencing, clock generation and shifting.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q <= SMP_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      div_q <= 16'h0000;
      sck_q <= 1'b0;
      bit_q <= 1'b0;
      prev_q <= 1'b0;
      o_rx <= 8'h00;
      o_done <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      prev_q <= link.sck;
      o_done <= fin;
      o_busy <= (state_q == SMP_XFER);
      if (state_q == SMP_IDLE)
        sck_q <= i_cpol;
      if (state_q == SMP_XFER && div_q != 16'h0000)
        div_q <= div_q - 16'h0001;
      else
        div_q <= 16'(HALF - 1);
      if (i_master && state_q == SMP_XFER && div_q == 16'h0000)
        sck_q <= ~sck_q;
      if ((i_master && i_start && state_q == SMP_IDLE) || (!i_master && !i_sel))
      begin
        sh_q <= i_tx;
        cnt_q <= 4'h0;
        if (i_master)
          state_q <= SMP_XFER;
      end
      else
      begin
        if (ev)
          cnt_q <= cnt_q + 4'h1;
        if (samp)
          bit_q <= in_bit;
        if (shft && !(i_clock_phase_select && cnt_q == 4'h0))
          sh_q <= {sh_q[6:0], bit_q};
        if (samp && i_clock_phase_select && last)
          o_rx <= {sh_q[6:0], in_bit};
        if (shft && !i_clock_phase_select && last)
          o_rx <= {sh_q[6:0], bit_q};
        if (fin)
        begin
          state_q <= SMP_IDLE;
          if (!i_master)
            sh_q <= i_tx;
        end
      end
    end
  end
endmodule : smp_peer

// [dv/smp_link_checker.sv]
// Checker of the serial bus lines shared by the port and its partner.
module smp_link_checker (
  input wire logic i_sys_clk, // Clock.
  input wire logic i_rst_b, // Reset, active low.
  input wire logic sck, // Clock line.
  input wire logic ss_n, // Select line.
  input wire logic dev_sck_oe, // Port drives clock.
  input wire logic dev_mosi_oe, // Port drives out line.
  input wire logic dev_miso_oe, // Port drives in line.
  input wire logic peer_sck_oe, // Partner drives clock.
  input wire logic peer_miso_oe // Partner drives in line.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sck_q, oe_q, idle_q, chg;
  logic [3:0] tog_q;
  logic [7:0] run_q, prev_q;
  // An edge of the clock line while the port drives it.
  assign chg = dev_sck_oe && oe_q && (sck != sck_q);
  // Counts edges within a byte and the cycles between them.
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sck_q <= 1'b0;
      oe_q <= 1'b0;
      idle_q <= 1'b0;
      tog_q <= 4'h0;
      run_q <= 8'h00;
      prev_q <= 8'h00;
    end
    else
    begin
      sck_q <= sck;
      oe_q <= dev_sck_oe;
      run_q <= chg ? 8'h01 : (run_q == 8'hff ? run_q : run_q + 8'h01);
      if (chg) prev_q <= run_q;
      if (chg && tog_q == 4'h0) idle_q <= sck_q;
      tog_q <= !dev_sck_oe ? 4'h0 : (chg ? tog_q + 4'h1 : tog_q);
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);
  // Line ownership and byte framing.
  AST_MISO_FLOAT: assert property (ss_n && $past(ss_n) |-> !dev_miso_oe) else $error("in line driven unselected");
  AST_OE_PAIR: assert property (dev_sck_oe == dev_mosi_oe) else $error("clock and out line owners differ");
  AST_MISO_ONE: assert property (!(dev_miso_oe && peer_miso_oe)) else $error("two drivers on in line");
  AST_SCK_HALF: assert property (chg |-> run_q >= 8'h02) else $error("half period too short");
  AST_RATE_EVEN: assert property (chg && tog_q > 4'h1 |-> run_q == prev_q) else $error("uneven half period");
  AST_IDLE_LEVEL: assert property (chg && tog_q == 4'hf |-> sck == idle_q) else $error("clock not at idle");
  AST_BYTE_WHOLE: assert property (dev_sck_oe && tog_q != 4'h0 |-> ##[0:64] (chg || !dev_sck_oe))
    else $error("byte stopped early");
  AST_SS_FRAME: assert property (peer_sck_oe && $past(peer_sck_oe) && !dev_sck_oe && !$past(dev_sck_oe)
    && $changed(sck) |-> !ss_n) else $error("partner clocks unselected");
  // Main scenarios reached.
  cover property (chg && tog_q == 4'hf);
  cover property ($fell(ss_n));
  cover property (dev_miso_oe);
endmodule : smp_link_checker

// [dv/spi_master_slave_port_tb_top.sv]
// Testbench joining the port and its partner over the serial bus.
module spi_master_slave_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import smp_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, irq, err_q, sck_p;
  logic [31:0] prdata, rd;
  logic p_master = 1'b0, p_sel = 1'b0, p_cpol = 1'b0, p_clock_phase_select = 1'b0, p_start = 1'b0;
  logic [7:0] p_tx = 8'h00;
  logic [7:0] p_rx;
  logic p_done, p_busy;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_edge = 0;
  int half_seen = 0;
  int run = 0;
  smp_link_if link ();
  smp_device u_smp_device (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .o_irq_req(irq), .link(link.dev));
  smp_peer #(.HALF(2)) u_smp_peer (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_master(p_master),
    .i_sel(p_sel), .i_cpol(p_cpol), .i_clock_phase_select(p_clock_phase_select), .i_start(p_start), .i_tx(p_tx), .o_rx(p_rx),
    .o_done(p_done), .o_busy(p_busy), .link(link.peer));
  smp_link_checker u_smp_link_checker (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .sck(link.sck),
    .ss_n(link.ss_n), .dev_sck_oe(link.dev_sck_oe), .dev_mosi_oe(link.dev_mosi_oe),
    .dev_miso_oe(link.dev_miso_oe), .peer_sck_oe(link.peer_sck_oe), .peer_miso_oe(link.peer_miso_oe));
  // Clock of 100 ns.
  initial forever #50 i_sys_clk = ~i_sys_clk;
  // Counts clock line edges and the length of the last half period.
  always @(posedge i_sys_clk)
  begin
    sck_p <= link.sck;
    if (link.sck !== sck_p)
    begin
      n_edge <= n_edge + 1;
      half_seen <= run;
      run <= 1;
    end
    else
      run <= run + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    pen <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang.
    do
    begin
      @(posedge i_sys_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_sys_clk);
  endtask : apb
  task automatic cfg(input logic [7:0] c);
    apb(1'b1, SMP_CTRL_OFF, 32'h0);
    apb(1'b1, SMP_CTRL_OFF, {24'h0, c});
    @(posedge i_sys_clk);
  endtask : cfg
  task automatic wait_irq();
    while (irq !== 1'b1)
    begin
      @(posedge i_sys_clk);
    end
  endtask : wait_irq
  task automatic peer_byte();
    p_master <= 1'b1;
    @(posedge i_sys_clk);
    p_start <= 1'b1;
    @(posedge i_sys_clk);
    p_start <= 1'b0;
  endtask : peer_byte
  // Register values after reset and an unmapped address.
  task automatic t_reset();
    apb(1'b0, SMP_CTRL_OFF, 32'h0);
    chk(rd, {24'h0, SMP_CTRL_RESET});
    apb(1'b0, SMP_STAT_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, SMP_DATA_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk({31'h0, err_q}, 32'h1);
  endtask : t_reset
  // Port as master at every rate code, reserved ones included.
  task automatic t_master();
    logic [7:0] tx;
    int e0;
    for (int r = 0; r < 8; r++)
    begin
      tx = 8'h96 ^ 8'(r * 37);
      p_cpol <= r[1];
      p_clock_phase_select <= r[0];
      p_sel <= 1'b0;
      p_tx <= ~tx;
      cfg({2'b11, 1'b0, r[1], r[0], r[2:0]});
      p_sel <= 1'b1;
      chk({31'h0, link.sck}, {31'h0, r[1]});
      // Lets the edge counter absorb the move to the idle level before the baseline is taken.
      @(posedge i_sys_clk);
      e0 = n_edge;
      apb(1'b1, SMP_DATA_OFF, {24'h0, tx});
      if (r == 0 || r == 7)
      begin
        repeat (200) @(posedge i_sys_clk);
        chk(n_edge - e0, 0);
        apb(1'b0, SMP_STAT_OFF, 32'h0);
        chk(rd & 32'h81, 32'h0);
      end
      else
      begin
        wait_irq();
        repeat (2) @(posedge i_sys_clk);
        chk(n_edge - e0, 16);
        chk(half_seen, 32'(1 << r));
        chk({24'h0, p_rx}, {24'h0, tx});
        apb(1'b0, SMP_STAT_OFF, 32'h0);
        apb(1'b0, SMP_DATA_OFF, 32'h0);
        chk(rd, {24'h0, ~tx});
      end
    end
  endtask : t_master
  // A data write in mid-transfer.
  task automatic t_write_collision_flag();
    p_sel <= 1'b0;
    p_cpol <= 1'b0;
    p_clock_phase_select <= 1'b0;
    cfg(8'hc3);
    p_sel <= 1'b1;
    apb(1'b1, SMP_DATA_OFF, 32'h5a);
    apb(1'b1, SMP_DATA_OFF, 32'ha5);
    apb(1'b0, SMP_STAT_OFF, 32'h0);
    chk({31'h0, rd[SMP_ST_WRITE_COLLISION_FLAG]}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wait_irq();
    repeat (2) @(posedge i_sys_clk);
    chk({24'h0, p_rx}, 32'h5a);
    apb(1'b0, SMP_STAT_OFF, 32'h0);
    apb(1'b0, SMP_DATA_OFF, 32'h0);
    apb(1'b0, SMP_STAT_OFF, 32'h0);
    chk(rd, 32'h0);
  endtask : t_write_collision_flag
  // Port as slave in both clock phases.
  task automatic t_slave();
    p_sel <= 1'b0;
    for (int b = 0; b < 2; b++)
    begin
      p_clock_phase_select <= b[0];
      p_tx <= 8'hc5 ^ 8'(b);
      cfg({4'h8, b[0], 3'h0});
      apb(1'b1, SMP_DATA_OFF, 32'h3c ^ 32'(b));
      peer_byte();
      wait_irq();
      repeat (4) @(posedge i_sys_clk);
      chk({24'h0, p_rx}, 32'h3c ^ 32'(b));
      chk({31'h0, link.dev_miso_oe}, 32'h0);
      chk({31'h0, p_busy}, 32'h0);
      apb(1'b0, SMP_STAT_OFF, 32'h0);
      apb(1'b0, SMP_DATA_OFF, 32'h0);
      chk(rd, 32'hc5 ^ 32'(b));
      p_master <= 1'b0;
    end
  endtask : t_slave
  // Select driven low against the port as master.
  task automatic t_mode_fault_flag();
    p_clock_phase_select <= 1'b0;
    cfg(8'he1);
    peer_byte();
    repeat (60) @(posedge i_sys_clk);
    apb(1'b0, SMP_STAT_OFF, 32'h0);
    chk({31'h0, rd[SMP_ST_MODE_FAULT_FLAG]}, 32'h0);
    p_master <= 1'b0;
    cfg(8'hc1);
    peer_byte();
    wait_irq();
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, SMP_CTRL_OFF, 32'h0);
    chk(rd, 32'h01);
    repeat (60) @(posedge i_sys_clk);
    p_master <= 1'b0;
    apb(1'b1, SMP_CTRL_OFF, 32'h20);
    apb(1'b1, SMP_CTRL_OFF, 32'h00);
    apb(1'b0, SMP_STAT_OFF, 32'h0);
    chk({31'h0, rd[SMP_ST_MODE_FAULT_FLAG]}, 32'h1);
    apb(1'b1, SMP_CTRL_OFF, 32'h00);
    apb(1'b0, SMP_STAT_OFF, 32'h0);
    chk({31'h0, rd[SMP_ST_MODE_FAULT_FLAG]}, 32'h0);
  endtask : t_mode_fault_flag
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  // Main sequence after 16 cycles of reset.
  initial
  begin
    repeat (16) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    @(posedge i_sys_clk);
    t_reset();
    t_master();
    t_write_collision_flag();
    t_slave();
    t_mode_fault_flag();
    close_out();
  end
  // Watchdog against a hang.
  initial
  begin
    repeat (30000) @(posedge i_sys_clk);
    n_mismatch++;
    close_out();
  end
endmodule : spi_master_slave_port_tb_top
